/* cjh_pkg.sv */
package cjh_pkg;
	// Clock rate, used to turn ramp seconds into cycles
	localparam int unsigned CLK_HZ = 20_000_000;
	// Full line speed in 0.1 percent steps
	localparam logic [10:0] SPD_FULL = 11'h3E8;
	// -------------------------------------------------------------
	// Register byte offsets
	// -------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_ALARM_POS = 8'h04;
	localparam logic [7:0] OFS_JOGF_SPD = 8'h08;
	localparam logic [7:0] OFS_JOGF_UP = 8'h0C;
	localparam logic [7:0] OFS_JOGF_DN = 8'h10;
	localparam logic [7:0] OFS_JOGR_SPD = 8'h14;
	localparam logic [7:0] OFS_JOGR_UP = 8'h18;
	localparam logic [7:0] OFS_JOGR_DN = 8'h1C;
	localparam logic [7:0] OFS_HOME_HI = 8'h20;
	localparam logic [7:0] OFS_HOME_LO = 8'h24;
	localparam logic [7:0] OFS_HOME_RAMP = 8'h28;
	localparam logic [7:0] OFS_HOME_DIST = 8'h2C;
	localparam logic [7:0] OFS_HOME_WIN = 8'h30;
	localparam logic [7:0] OFS_STATUS = 8'h34;
	localparam logic [7:0] OFS_POS = 8'h38;
	localparam logic [7:0] OFS_CUT_HOME = 8'h3C;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h40;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h44;
	// -------------------------------------------------------------
	// Field positions and reset values
	// -------------------------------------------------------------
	localparam int CTRL_INTERLOCK = 0;
	localparam int CTRL_HOME_GO = 1;
	localparam int IRQ_NOHOME = 0;
	localparam int IRQ_ALARM = 1;
	localparam int IRQ_HDONE = 2;
	localparam logic [19:0] RST_ALARM_POS = 20'hF423F;
	localparam logic [9:0] RST_SPEED = 10'h032;
	localparam logic [6:0] RST_RAMP = 7'h01;
	localparam logic [16:0] RST_HOME_DIST = 17'h00000;
	localparam logic [9:0] RST_HOME_WIN = 10'h064;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Homing sequence, Gray coded along the path
	typedef enum logic [1:0] {
		HS_IDLE = 2'h0,
		HS_SEEK = 2'h1,
		HS_APPROACH = 2'h3,
		HS_STOP = 2'h2
	} cjh_home_t;
endpackage : cjh_pkg

/* cjh_carriage_ctrl.sv */
`timescale 1ns/100ps
module cjh_carriage_ctrl (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic cut_run_request,
	input wire logic single_cut_request,
	input wire logic ref_sensor,
	input wire logic jog_forward_request,
	input wire logic jog_reverse_request,
	input wire logic signed [31:0] carriage_pos,
	output logic signed [10:0] speed_setpoint,
	output logic carriage_home,
	output logic carriage_alarm,
	output logic homing_done,
	output logic homing_missing,
	output logic cut_start,
	output logic irq
);
	import cjh_pkg::*;

	// -------------------------------------------------------------
	// Helpers
	// -------------------------------------------------------------
	function automatic logic [31:0] wmerge(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (s[i])
				r[i*8 +: 8] = d[i*8 +: 8];
		end
		return r;
	endfunction : wmerge

	function automatic logic [10:0] mag11(input logic signed [10:0] v);
		return v[10] ? 11'(-v) : v;
	endfunction : mag11

	// Ramp seconds to cycles; zero is taken as one second
	function automatic logic [31:0] ramp_cycles(input logic [6:0] s);
		logic [31:0] n;
		n = (s == 7'h00) ? 32'h1 : 32'(s);
		return 32'(n * CLK_HZ);
	endfunction : ramp_cycles

	// -------------------------------------------------------------
	// Registers
	// -------------------------------------------------------------
	logic interlock_r;
	logic [19:0] alarm_pos_r;
	logic [9:0] jogf_spd_r, jogr_spd_r, home_hi_r, home_lo_r;
	logic [6:0] jogf_up_r, jogf_dn_r, jogr_up_r, jogr_dn_r, home_ramp_r;
	logic [16:0] home_dist_r;
	logic [9:0] home_win_r;
	logic [2:0] irq_stat_r, irq_mask_r;
	logic aw_got_r, w_got_r;
	logic [7:0] aw_addr_r, ar_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic bvalid_r, rvalid_r;
	logic [1:0] bresp_r, rresp_r;
	logic [31:0] rdata_r;
	logic ref_init_r, ref_q_r, cut_q_r, single_q_r;
	logic signed [31:0] ref_pos_r, cut_home_r;
	cjh_home_t hs_r;
	logic signed [10:0] speed_r;
	logic [31:0] acc_r;
	logic done_r, missing_r, alarm_r, home_r, start_r;

	// -------------------------------------------------------------
	// Bus handshakes and decode
	// -------------------------------------------------------------
	wire wr_fire = aw_got_r && w_got_r && !bvalid_r;
	wire rd_fire = s_axi_arvalid && s_axi_arready;
	wire [7:0] wa = aw_addr_r;
	wire [31:0] wd = wmerge(32'h0, w_data_r, w_strb_r);
	wire wr_mapped = (wa[1:0] == 2'h0) && (wa <= OFS_IRQ_MASK);
	wire wr_ctrl = wr_fire && (wa == OFS_CTRL);
	wire home_go = wr_ctrl && w_strb_r[0] && w_data_r[CTRL_HOME_GO];
	wire wr_iclr = wr_fire && (wa == OFS_IRQ_STAT);
	assign s_axi_awready = !aw_got_r && !bvalid_r;
	assign s_axi_wready = !w_got_r && !bvalid_r;
	assign s_axi_arready = !rvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rdata = rdata_r;

	// Address and data may arrive in either order
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			aw_addr_r <= 8'h00;
			w_data_r <= 32'h0;
			w_strb_r <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_got_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_got_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			if (wr_fire)
			begin
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_bready)
				bvalid_r <= 1'b0;
		end
	end

	// -------------------------------------------------------------
	// Positions and input edges
	// -------------------------------------------------------------
	wire signed [31:0] pos_rel = carriage_pos - ref_pos_r;
	wire ref_fall = ref_q_r && !ref_sensor;
	wire cut_rise = cut_run_request && !cut_q_r;
	wire cut_req = cut_rise || (single_cut_request && !single_q_r);
	wire signed [31:0] home_diff = pos_rel - cut_home_r;
	wire [31:0] home_mag = home_diff[31] ? 32'(-home_diff) : home_diff;
	wire in_win = home_mag <= {22'h0, home_win_r};
	wire beyond = pos_rel > $signed({12'h0, alarm_pos_r});

	// Reference is caught on the first edge after reset release
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ref_init_r <= 1'b0;
			ref_pos_r <= 32'sh0;
			cut_home_r <= 32'sh0;
			ref_q_r <= 1'b0;
			cut_q_r <= 1'b0;
			single_q_r <= 1'b0;
		end
		else
		begin
			ref_init_r <= 1'b1;
			ref_q_r <= ref_sensor;
			cut_q_r <= cut_run_request;
			single_q_r <= single_cut_request;
			if (!ref_init_r || ref_fall)
				ref_pos_r <= carriage_pos;
			if (cut_rise)
				cut_home_r <= pos_rel;
		end
	end

	// -------------------------------------------------------------
	// Speed target and ramp selection
	// -------------------------------------------------------------
	wire homing = hs_r != HS_IDLE;
	wire jf_only = jog_forward_request && !jog_reverse_request;
	wire jr_only = jog_reverse_request && !jog_forward_request;
	logic signed [10:0] target;
	always_comb
	begin
		target = 11'sh0;
		if (hs_r == HS_SEEK)
			target = -$signed({1'b0, home_hi_r});
		else if (hs_r == HS_APPROACH)
			target = $signed({1'b0, home_lo_r});
		else if (hs_r == HS_STOP)
			target = 11'sh0;
		else if (jf_only)
			target = $signed({1'b0, jogf_spd_r});
		else if (jr_only)
			target = -$signed({1'b0, jogr_spd_r});
	end

	// Speeding up only while same sign and magnitude still below target
	wire same_dir = (speed_r == 11'sh0) || (speed_r[10] == target[10]);
	wire accel = same_dir && (target != 11'sh0) &&
		(mag11(target) > mag11(speed_r));
	wire fwd_dir = (speed_r > 11'sh0) ||
		((speed_r == 11'sh0) && (target > 11'sh0));
	wire [6:0] jf_secs = accel ? jogf_up_r : jogf_dn_r;
	wire [6:0] jr_secs = accel ? jogr_up_r : jogr_dn_r;
	wire [6:0] jog_secs = fwd_dir ? jf_secs : jr_secs;
	wire [6:0] secs = homing ? home_ramp_r : jog_secs;
	wire [31:0] lim = ramp_cycles(secs);
	wire [31:0] acc_sum = acc_r + 32'(SPD_FULL);
	wire step = acc_sum >= lim;

	// One 0.1 % step per lim/1000 cycles gives full speed in secs
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			speed_r <= 11'sh0;
			acc_r <= 32'h0;
		end
		else if (speed_r == target)
			acc_r <= 32'h0;
		else if (step)
		begin
			acc_r <= acc_sum - lim;
			speed_r <= (target > speed_r) ? speed_r + 11'sh1 :
				speed_r - 11'sh1;
		end
		else
			acc_r <= acc_sum;
	end

	// -------------------------------------------------------------
	// Homing sequence
	// -------------------------------------------------------------
	// Sensor edge also resets zero, so the distance counts from it
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			hs_r <= HS_IDLE;
			done_r <= 1'b0;
		end
		else
		begin
			case (hs_r)
				HS_IDLE:
					if (home_go)
						hs_r <= HS_SEEK;
				HS_SEEK:
					if (ref_fall)
						hs_r <= HS_APPROACH;
				HS_APPROACH:
					if (pos_rel >= $signed({15'h0, home_dist_r}))
						hs_r <= HS_STOP;
				HS_STOP:
					if (speed_r == 11'sh0)
					begin
						hs_r <= HS_IDLE;
						done_r <= 1'b1;
					end
				default:
					hs_r <= HS_IDLE;
			endcase
		end
	end

	// -------------------------------------------------------------
	// Cut interlock and position outputs
	// -------------------------------------------------------------
	wire blocked = interlock_r && !done_r;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			start_r <= 1'b0;
			missing_r <= 1'b0;
			alarm_r <= 1'b0;
			home_r <= 1'b0;
		end
		else
		begin
			start_r <= cut_req && !blocked;
			if (cut_req && blocked)
				missing_r <= 1'b1;
			else if (done_r)
				missing_r <= 1'b0;
			alarm_r <= cut_run_request && beyond;
			home_r <= in_win;
		end
	end
	assign speed_setpoint = speed_r;
	assign homing_done = done_r;
	assign homing_missing = missing_r;
	assign cut_start = start_r;
	assign carriage_alarm = alarm_r;
	assign carriage_home = home_r;

	// -------------------------------------------------------------
	// Interrupt status, set wins over write-one-clear
	// -------------------------------------------------------------
	wire done_rise = (hs_r == HS_STOP) && (speed_r == 11'sh0);
	wire alarm_rise = cut_run_request && beyond && !alarm_r;
	wire [2:0] irq_set = {done_rise, alarm_rise, cut_req && blocked};
	wire [2:0] irq_clr = (wr_iclr && w_strb_r[0]) ? w_data_r[2:0] : 3'h0;
	assign irq = |(irq_stat_r & irq_mask_r);

	// -------------------------------------------------------------
	// Settings write
	// -------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			interlock_r <= 1'b0;
			alarm_pos_r <= RST_ALARM_POS;
			jogf_spd_r <= RST_SPEED;
			jogr_spd_r <= RST_SPEED;
			home_hi_r <= RST_SPEED;
			home_lo_r <= RST_SPEED;
			jogf_up_r <= RST_RAMP;
			jogf_dn_r <= RST_RAMP;
			jogr_up_r <= RST_RAMP;
			jogr_dn_r <= RST_RAMP;
			home_ramp_r <= RST_RAMP;
			home_dist_r <= RST_HOME_DIST;
			home_win_r <= RST_HOME_WIN;
			irq_stat_r <= 3'h0;
			irq_mask_r <= 3'h0;
		end
		else
		begin
			irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
			if (wr_ctrl && w_strb_r[0])
				interlock_r <= w_data_r[CTRL_INTERLOCK];
			if (wr_fire && wa == OFS_ALARM_POS)
				alarm_pos_r <= wd[19:0];
			if (wr_fire && wa == OFS_JOGF_SPD)
				jogf_spd_r <= wd[9:0];
			if (wr_fire && wa == OFS_JOGF_UP)
				jogf_up_r <= wd[6:0];
			if (wr_fire && wa == OFS_JOGF_DN)
				jogf_dn_r <= wd[6:0];
			if (wr_fire && wa == OFS_JOGR_SPD)
				jogr_spd_r <= wd[9:0];
			if (wr_fire && wa == OFS_JOGR_UP)
				jogr_up_r <= wd[6:0];
			if (wr_fire && wa == OFS_JOGR_DN)
				jogr_dn_r <= wd[6:0];
			if (wr_fire && wa == OFS_HOME_HI)
				home_hi_r <= wd[9:0];
			if (wr_fire && wa == OFS_HOME_LO)
				home_lo_r <= wd[9:0];
			if (wr_fire && wa == OFS_HOME_RAMP)
				home_ramp_r <= wd[6:0];
			if (wr_fire && wa == OFS_HOME_DIST)
				home_dist_r <= wd[16:0];
			if (wr_fire && wa == OFS_HOME_WIN)
				home_win_r <= wd[9:0];
			if (wr_fire && wa == OFS_IRQ_MASK)
				irq_mask_r <= wd[2:0];
		end
	end

	// -------------------------------------------------------------
	// Read path
	// -------------------------------------------------------------
	logic [31:0] rd_val;
	logic rd_ok;
	wire [7:0] ra = s_axi_araddr;
	always_comb
	begin
		rd_ok = 1'b1;
		rd_val = 32'h0;
		if (ra == OFS_CTRL)
			rd_val = {31'h0, interlock_r};
		else if (ra == OFS_ALARM_POS)
			rd_val = {12'h0, alarm_pos_r};
		else if (ra == OFS_JOGF_SPD)
			rd_val = {22'h0, jogf_spd_r};
		else if (ra == OFS_JOGF_UP)
			rd_val = {25'h0, jogf_up_r};
		else if (ra == OFS_JOGF_DN)
			rd_val = {25'h0, jogf_dn_r};
		else if (ra == OFS_JOGR_SPD)
			rd_val = {22'h0, jogr_spd_r};
		else if (ra == OFS_JOGR_UP)
			rd_val = {25'h0, jogr_up_r};
		else if (ra == OFS_JOGR_DN)
			rd_val = {25'h0, jogr_dn_r};
		else if (ra == OFS_HOME_HI)
			rd_val = {22'h0, home_hi_r};
		else if (ra == OFS_HOME_LO)
			rd_val = {22'h0, home_lo_r};
		else if (ra == OFS_HOME_RAMP)
			rd_val = {25'h0, home_ramp_r};
		else if (ra == OFS_HOME_DIST)
			rd_val = {15'h0, home_dist_r};
		else if (ra == OFS_HOME_WIN)
			rd_val = {22'h0, home_win_r};
		else if (ra == OFS_STATUS)
			rd_val = {10'h0, {5{speed_r[10]}}, mag11(speed_r), hs_r,
				missing_r, home_r, alarm_r, done_r};
		else if (ra == OFS_POS)
			rd_val = pos_rel;
		else if (ra == OFS_CUT_HOME)
			rd_val = cut_home_r;
		else if (ra == OFS_IRQ_STAT)
			rd_val = {29'h0, irq_stat_r};
		else if (ra == OFS_IRQ_MASK)
			rd_val = {29'h0, irq_mask_r};
		else
			rd_ok = 1'b0; // Unmapped answers SLVERR, data zero
	end

	// Read data one cycle after the address is taken
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0;
			rresp_r <= RESP_OKAY;
		end
		else if (rd_fire)
		begin
			rvalid_r <= 1'b1;
			rdata_r <= rd_val;
			rresp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_rready)
			rvalid_r <= 1'b0;
	end
endmodule : cjh_carriage_ctrl

/* cjh_carriage_ctrl_asserts.sv */
`timescale 1ns/100ps
module cjh_carriage_ctrl_asserts (
	input logic aclk,
	input logic aresetn,
	input logic s_axi_awvalid,
	input logic s_axi_awready,
	input logic s_axi_wvalid,
	input logic s_axi_wready,
	input logic s_axi_bvalid,
	input logic s_axi_arvalid,
	input logic s_axi_arready,
	input logic s_axi_rvalid,
	input logic cut_run_request,
	input logic single_cut_request,
	input logic signed [10:0] speed_setpoint,
	input logic carriage_alarm,
	input logic homing_done,
	input logic homing_missing,
	input logic cut_start
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// ----------------------------------------------------------
	// Cut control
	// ----------------------------------------------------------
	property p_cut_pulse;
		cut_start |=> !cut_start;
	endproperty
	a_cut_pulse: assert property (p_cut_pulse)
		else $error("cut start held past one cycle");
	property p_cut_cause;
		cut_start |-> $past(cut_run_request) || $past(single_cut_request);
	endproperty
	a_cut_cause: assert property (p_cut_cause)
		else $error("cut start without a request");
	property p_alarm_run;
		carriage_alarm |-> $past(cut_run_request);
	endproperty
	a_alarm_run: assert property (p_alarm_run)
		else $error("alarm outside automatic cutting");
	// ----------------------------------------------------------
	// Homing
	// ----------------------------------------------------------
	property p_done_sticky;
		homing_done |=> homing_done;
	endproperty
	a_done_sticky: assert property (p_done_sticky)
		else $error("homing done dropped without reset");
	property p_miss_clr;
		$rose(homing_done) |-> ##[0:2] !homing_missing;
	endproperty
	a_miss_clr: assert property (p_miss_clr)
		else $error("missing homing kept after homing done");
	// ----------------------------------------------------------
	// Speed ramp: single steps, far apart at any legal ramp
	// ----------------------------------------------------------
	property p_ramp_step;
		$changed(speed_setpoint) |->
			speed_setpoint == $past(speed_setpoint) + 11'sh001 ||
			speed_setpoint == $past(speed_setpoint) - 11'sh001;
	endproperty
	a_ramp_step: assert property (p_ramp_step)
		else $error("setpoint jumped by more than one step");
	property p_ramp_gap;
		$changed(speed_setpoint) |=> $stable(speed_setpoint)[*8];
	endproperty
	a_ramp_gap: assert property (p_ramp_gap)
		else $error("setpoint steps too close together");
	// ----------------------------------------------------------
	// Register bus answer latency
	// ----------------------------------------------------------
	property p_wr_lat;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			|-> ##2 s_axi_bvalid;
	endproperty
	a_wr_lat: assert property (p_wr_lat)
		else $error("write response late");
	property p_rd_lat;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd_lat: assert property (p_rd_lat)
		else $error("read data late");
	c_cut: cover property (cut_start);
	c_done: cover property ($rose(homing_done));
	c_alarm: cover property ($rose(carriage_alarm));
endmodule : cjh_carriage_ctrl_asserts

bind cjh_carriage_ctrl cjh_carriage_ctrl_asserts u_chk (.aclk, .aresetn,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.cut_run_request, .single_cut_request, .speed_setpoint,
	.carriage_alarm, .homing_done, .homing_missing, .cut_start);

/* cjh_drive_model.sv */
`timescale 1ns/100ps
module cjh_drive_model #(
	parameter int START = 500,
	parameter int SENS = 100
) (
	input logic aclk,
	input logic aresetn,
	input logic signed [10:0] speed_setpoint,
	input logic signed [31:0] nudge,
	output logic signed [31:0] carriage_pos,
	output logic ref_sensor
);
	// Drive integrates setpoint; nudge stands for a push by hand
	// Held at start while in reset, so an unset setpoint never leaks in
	always @(posedge aclk)
		if (!aresetn)
			carriage_pos <= START;
		else
			carriage_pos <= carriage_pos + speed_setpoint + nudge;
	// Sensor flag covers travel at and beyond its mount point
	assign ref_sensor = carriage_pos >= SENS;
endmodule : cjh_drive_model

/* cjh_carriage_ctrl_tb.sv */
`timescale 1ns/100ps
module cjh_carriage_ctrl_tb;
	import cjh_pkg::*;
	logic aclk = '0;
	logic aresetn = '0;
	logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
	logic s_axi_arvalid = '0, s_axi_rready = '0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr;
	logic cut_run_request = '0, single_cut_request = '0;
	logic jog_forward_request = '0, jog_reverse_request = '0;
	logic ref_sensor, carriage_home, carriage_alarm, homing_done;
	logic homing_missing, cut_start, irq, seen;
	logic signed [31:0] carriage_pos;
	logic signed [31:0] nudge = '0;
	logic signed [10:0] speed_setpoint;
	logic [31:0] rd;
	int n_fail = 0;
	int checks = 0;
	int n;

	cjh_carriage_ctrl dut (.*);
	cjh_drive_model u_drive (.aclk, .aresetn, .speed_setpoint, .nudge,
		.carriage_pos, .ref_sensor);

	initial forever #25 aclk = ~aclk;
	// ----------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------
	task test_done;
		if (n_fail == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : test_done
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task cyc(input int k);
		repeat (k) @(posedge aclk);
	endtask : cyc
	// Both channels offered together, each dropped once taken
	task axw(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'h0;
		end
		while (s_axi_bvalid !== 1'h1);
		rr = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask : axw
	task axr(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'h0;
		end
		while (s_axi_rvalid !== 1'h1);
		rd = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask : axr
	// Strobe is one cycle wide, so watch every edge
	task see_cut;
		seen = 1'h0;
		repeat (4)
		begin
			@(posedge aclk);
			if (cut_start === 1'h1)
				seen = 1'h1;
		end
	endtask : see_cut
	// Full speed per ramp second, 1000 steps, so a unit step is 20000 cycles
	task ramp_to(input logic signed [10:0] tgt);
		n = 0;
		while (speed_setpoint !== tgt && n < 25000)
		begin
			@(posedge aclk);
			n++;
		end
		chk(n >= 19990 && n <= 20010, 32'h1);
	endtask : ramp_to
	task push(input logic signed [31:0] v);
		@(posedge aclk);
		nudge <= v;
		@(posedge aclk);
		nudge <= '0;
		cyc(3);
	endtask : push
	// ----------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------
	task t_reset_vals;
		axr(OFS_ALARM_POS);
		chk(rd, RST_ALARM_POS);
		axr(OFS_HOME_WIN);
		chk(rd, RST_HOME_WIN);
		axr(OFS_POS);
		chk(rd, 32'h0);
		axr(8'h48);
		chk(rr, RESP_SLVERR);
		chk(rd, 32'h0);
		axw(8'h4C, 32'h5);
		chk(rr, RESP_SLVERR);
	endtask : t_reset_vals
	task t_no_lock;
		single_cut_request <= 1'h1;
		see_cut;
		chk(seen, 1'h1);
		single_cut_request <= 1'h0;
	endtask : t_no_lock
	task t_lock_refuse;
		axw(OFS_IRQ_MASK, 32'h7);
		axw(OFS_CTRL, 32'h1);
		cut_run_request <= 1'h1;
		see_cut;
		chk(seen, 1'h0);
		chk(homing_missing, 1'h1);
		chk(irq, 1'h1);
		axr(OFS_IRQ_STAT);
		chk(rd, 32'h1);
		axw(OFS_IRQ_MASK, 32'h0);
		cyc(1);
		chk(irq, 1'h0);
		axw(OFS_IRQ_STAT, 32'h1);
		axr(OFS_IRQ_STAT);
		chk(rd, 32'h0);
		cut_run_request <= 1'h0;
	endtask : t_lock_refuse
	// Zero speeds keep the carriage still, so the zero is exact
	task t_homing;
		axw(OFS_HOME_HI, 32'h0);
		axw(OFS_HOME_LO, 32'h0);
		axw(OFS_HOME_DIST, 32'h10);
		axw(OFS_CTRL, 32'h3);
		axr(OFS_STATUS);
		chk(rd[5:4], 2'h1);
		push(-32'sh1C2);
		axr(OFS_STATUS);
		chk(rd[5:4], 2'h3);
		chk(homing_done, 1'h0);
		push(32'sh10);
		n = 0;
		while (homing_done !== 1'h1 && n < 200)
		begin
			@(posedge aclk);
			n++;
		end
		chk(homing_done, 1'h1);
		cyc(3);
		chk(homing_missing, 1'h0);
		chk(homing_done, 1'h1);
		axr(OFS_POS);
		chk(rd, 32'h10);
	endtask : t_homing
	task t_cut_alarm;
		push(32'sh0E);
		cut_run_request <= 1'h1;
		see_cut;
		chk(seen, 1'h1);
		axr(OFS_CUT_HOME);
		chk(rd, 32'h1E);
		chk(carriage_home, 1'h1);
		chk(carriage_alarm, 1'h0);
		axw(OFS_ALARM_POS, 32'h14);
		cyc(3);
		chk(carriage_alarm, 1'h1);
		push(32'shC8);
		chk(carriage_home, 1'h0);
		axr(OFS_POS);
		chk(rd, 32'hE6);
		cut_run_request <= 1'h0;
		cyc(3);
		chk(carriage_alarm, 1'h0);
	endtask : t_cut_alarm
	task t_jog_fwd;
		axw(OFS_JOGF_SPD, 32'h1);
		jog_forward_request <= 1'h1;
		ramp_to(11'sh001);
		jog_forward_request <= 1'h0;
		ramp_to(11'sh000);
	endtask : t_jog_fwd
	task t_jog_rev;
		axw(OFS_JOGR_SPD, 32'h1);
		jog_reverse_request <= 1'h1;
		ramp_to(11'sh7FF);
		jog_reverse_request <= 1'h0;
		ramp_to(11'sh000);
	endtask : t_jog_rev
	// ----------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------
	initial
	begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		t_reset_vals;
		t_no_lock;
		t_lock_refuse;
		t_homing;
		t_cut_alarm;
		t_jog_fwd;
		t_jog_rev;
		test_done;
	end
	// Jog ramps dominate the run, about 80000 cycles
	initial
	begin
		#(95000 * 50);
		n_fail++;
		test_done;
	end
endmodule : cjh_carriage_ctrl_tb
